// ==== rtl/mtc_pkg.sv ====
// Shared constants and types of the five-channel timer common control.
package mtc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 5;
  localparam int GRW = 16;
  localparam int NPIN = 20;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RUN = 8'h00;
  localparam logic [7:0] OFS_LOCK = 8'h04;
  localparam logic [7:0] OFS_GATE = 8'h08;
  // Channel c occupies the 32-byte block numbered c + CH_BLK_FIRST.
  localparam logic [2:0] CH_BLK_FIRST = 3'h1;
  localparam logic [2:0] CH_BLK_LAST = 3'h5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_IOC = 5'h04;
  localparam logic [4:0] OFS_CNT = 5'h08;
  localparam logic [4:0] OFS_FLAG = 5'h0C;
  localparam logic [4:0] OFS_GR_A = 5'h10;

  // ----------------------------------------------------------------
  // Reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] LOCK_RST = 8'h00;
  localparam logic [5:0] GATE_RST = 6'h00;
  localparam logic [7:0] GATE_FIXED = 8'hC0;
  localparam logic [7:0] CH_BIT_MASK = 8'hC7;
  localparam logic [GRW-1:0] GR_RST = 16'hFFFF;
  localparam logic [GRW-1:0] CNT_RST = 16'h0000;

  // Bit of the run and lockstep registers that serves each channel.
  localparam int CH_BIT [0:NCH-1] = '{0, 1, 2, 6, 7};
  // Pin index (channel * 4 + register) served by each gate bit 0..5.
  localparam int GATE_PIN [0:5] = '{13, 16, 17, 15, 18, 19};

  // ----------------------------------------------------------------
  // Counter clear sources
  // ----------------------------------------------------------------
  localparam logic [2:0] CLR_NONE = 3'h0;
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_SYNC = 3'h3;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pwm;           // Complementary or reset-synchronised PWM.
    logic [3:0] cap;     // Per register: 1 capture role, 0 compare.
    logic buf_en;        // C buffers A, D buffers B.
    logic [2:0] clr_src; // Counter clear source.
  } mtc_ctrl_t;

  typedef struct packed {
    logic cnt_we;
    logic gr_we;
    logic [1:0] gr_sel;
    logic [GRW-1:0] data;
  } mtc_wr_t;

  function automatic int ch_ngr(int c);
    return (c == 1 || c == 2) ? 2 : 4;
  endfunction : ch_ngr

endpackage : mtc_pkg

// ==== rtl/mtc_lockstep_bit_ch2.sv ====
// Two-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
module mtc_lockstep_bit_ch2 #(
  parameter int W = 20
) (
  input wire logic clk,          // Peripheral clock.
  input wire logic reset,        // Asynchronous reset, active high.
  input wire logic [W-1:0] d,    // Asynchronous levels.
  output logic [W-1:0] q         // Synchronised levels.
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : mtc_lockstep_bit_ch2

// ==== rtl/mtc_chan.sv ====
// One timer channel: counter, general registers and their flags.
`timescale 1ns/1ps
module mtc_chan #(
  parameter int NGR = 4
) (
  input wire logic clk,                     // Peripheral clock.
  input wire logic reset,                   // Power-on reset.
  input wire logic standby,                 // Standby entry clear.
  input wire logic run,                     // Counter run bit.
  input wire mtc_pkg::mtc_ctrl_t ctrl,      // Channel configuration.
  input wire mtc_pkg::mtc_wr_t wr,          // Register writes.
  input wire logic flag_wr,                 // Flag register write.
  input wire logic sync_clr,                // Lockstep group clear.
  input wire logic [3:0] cap_edge,          // Capture pin edges.
  output logic [mtc_pkg::GRW-1:0] cnt,      // Counter value.
  output logic [3:0][mtc_pkg::GRW-1:0] gr,  // General registers.
  output logic [3:0] flags,                 // Match or capture flags.
  output logic [3:0] hit,                   // Compare matches.
  output logic clr_evt                      // Own clear event.
);

  logic [3:0] capt;
  logic [3:0] evt;
  logic [3:0] live;

  // In buffer mode C and D only buffer A and B and raise no events.
  always_comb begin
    live = (NGR == 4) ? 4'hF : 4'h3;
    if (ctrl.buf_en && NGR == 4) begin
      live = 4'h3;
    end
    for (int i = 0; i < 4; i++) begin
      hit[i] = live[i] && !ctrl.cap[i] && (cnt == gr[i]); // R21
      capt[i] = live[i] && ctrl.cap[i] && cap_edge[i]; // R21
    end
    evt = hit | capt;
  end

  always_comb begin
    case (ctrl.clr_src)
      mtc_pkg::CLR_A: clr_evt = evt[0];
      mtc_pkg::CLR_B: clr_evt = evt[1];
      mtc_pkg::CLR_C: clr_evt = evt[2];
      mtc_pkg::CLR_D: clr_evt = evt[3];
      default: clr_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= mtc_pkg::CNT_RST;
    end else if (standby) begin
      cnt <= mtc_pkg::CNT_RST;
    end else if (wr.cnt_we) begin
      cnt <= wr.data;
    end else if (clr_evt) begin
      cnt <= mtc_pkg::CNT_RST;
    end else if (sync_clr && ctrl.clr_src == mtc_pkg::CLR_SYNC) begin // R14
      cnt <= mtc_pkg::CNT_RST;
    end else if (run) begin
      cnt <= cnt + 16'h0001; // R22
    end
  end

  // ----------------------------------------------------------------
  // General registers
  // ----------------------------------------------------------------
  for (genvar j = 0; j < 4; j++) begin : g_gr
    logic from_buf;
    logic to_buf;
    if (j < 2 && NGR == 4) begin : g_lo
      assign from_buf = ctrl.buf_en && hit[j]; // R3
      assign to_buf = 1'b0;
    end else if (j >= 2 && NGR == 4) begin : g_hi
      assign from_buf = 1'b0;
      assign to_buf = ctrl.buf_en && capt[j-2]; // R3
    end else begin : g_none
      assign from_buf = 1'b0;
      assign to_buf = 1'b0;
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        gr[j] <= mtc_pkg::GR_RST; // R4
      end else if (standby || j >= NGR) begin
        gr[j] <= mtc_pkg::GR_RST; // R4
      end else if (wr.gr_we && wr.gr_sel == 2'(j)) begin
        gr[j] <= wr.data; // R1
      end else if (capt[j]) begin
        gr[j] <= cnt; // R21
      end else if (to_buf) begin
        gr[j] <= gr[(j + 2) % 4];
      end else if (from_buf) begin
        gr[j] <= gr[(j + 2) % 4];
      end
    end

    // A new event wins over a clearing write in the same cycle.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        flags[j] <= 1'b0;
      end else if (standby) begin
        flags[j] <= 1'b0;
      end else if (evt[j]) begin
        flags[j] <= 1'b1; // R21
      end else if (flag_wr && !wr.data[j]) begin
        flags[j] <= 1'b0;
      end
    end
  end

endmodule : mtc_chan

// ==== rtl/mtc_top.sv ====
// Five-channel timer common control with its APB register slave.
//
// Contract
// R1: Each general register is 16 bits, compare value or capture holder.
// R2: Channels 0, 3, 4 have registers A-D; channels 1, 2 have A, B.
// R3: On channels 0, 3, 4, C may buffer A and D may buffer B.
// R4: General registers reset to all ones by reset or standby.
// R5: Software accesses general registers only with full 16-bit transfers.
// R6: Run register: ch4 bit 7, ch3 bit 6, ch2-0 bits 2-0; 1 counts.
// R7: Run register clears to zero on reset or standby.
// R8: Clearing a run bit stops the counter; output pins hold level.
// R9: Pin control write while stopped drives the new initial level.
// R10: In PWM modes, clearing a run bit restores the initial level.
// R11: Bits 5-3 of run and lockstep registers read zero.
// R12: Lockstep register bits join counters to group preset and clear.
// R13: Software sets two lockstep bits; a counter write presets all.
// R14: Group clear needs the lockstep bit and the synchronous clear source.
// R15: Lockstep register clears to zero on reset or standby.
// R16: Gate register bits 5-0 enable pins 4D,4C,3D,4B,4A,3B.
// R17: Software programs gate bits before pin control of channels 3, 4.
// R18: Gate register resets to 0xC0, all six enables clear.
// R19: Gate register bits 7 and 6 always read as one.
// R20: A gate bit of 0 disables its pin output, 1 enables it.
// R21: Compare match sets the flag; capture loads the counter and flags.
// R22: A running counter advances each count clock; a stopped one holds.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module mtc_top (
  input wire logic clk,                 // Peripheral clock, 100 MHz.
  input wire logic reset,               // Power-on reset, active high.
  input wire logic standby,             // Standby entry, clears state.
  input wire logic psel,                // APB select.
  input wire logic penable,             // APB enable.
  input wire logic pwrite,              // APB write.
  input wire logic [7:0] paddr,         // APB byte address.
  input wire logic [31:0] pwdata,       // APB write data.
  input wire logic [3:0] pstrb,         // APB write strobes.
  output logic [31:0] prdata,           // APB read data.
  output logic pready,                  // APB ready.
  output logic pslverr,                 // APB error.
  input wire logic [19:0] tio_in,       // Timer pin input levels.
  output logic [19:0] tio_out,          // Timer pin output levels.
  output logic [19:0] tio_oe_n          // Timer pin drive, active low.
);

  localparam int NCH = mtc_pkg::NCH;
  localparam int GRW = mtc_pkg::GRW;
  localparam int NPIN = mtc_pkg::NPIN;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [2:0] blk;
  logic in_ch;
  logic [2:0] chn;
  logic [4:0] ofs;
  logic is_gr;
  logic [1:0] gr_idx;
  logic gr_ok;
  logic glob_ok;
  logic loc_ok;
  logic mapped;
  logic size_bad;
  logic err;
  logic acc;
  logic wr_en;

  assign blk = paddr[7:5];
  assign in_ch = (blk >= mtc_pkg::CH_BLK_FIRST) &&
                 (blk <= mtc_pkg::CH_BLK_LAST);
  assign chn = blk - mtc_pkg::CH_BLK_FIRST;
  assign ofs = paddr[4:0];
  assign is_gr = in_ch && (ofs >= mtc_pkg::OFS_GR_A);
  assign gr_idx = ofs[3:2];

  // Channels 1 and 2 have no C and D registers.
  assign gr_ok = (chn == 3'h1 || chn == 3'h2) ? !gr_idx[1] : 1'b1; // R2
  assign glob_ok = (paddr == mtc_pkg::OFS_RUN) ||
                   (paddr == mtc_pkg::OFS_LOCK) ||
                   (paddr == mtc_pkg::OFS_GATE);
  assign loc_ok = (ofs == mtc_pkg::OFS_CTRL) ||
                  (ofs == mtc_pkg::OFS_IOC) ||
                  (ofs == mtc_pkg::OFS_CNT) ||
                  (ofs == mtc_pkg::OFS_FLAG) ||
                  (is_gr && gr_ok);
  assign mapped = (paddr[1:0] == 2'b00) && (in_ch ? loc_ok : glob_ok);

  // Byte writes to 16-bit counters or general registers are refused.
  assign size_bad = pwrite && in_ch &&
                    (is_gr || ofs == mtc_pkg::OFS_CNT) &&
                    (pstrb[1:0] != 2'b11); // R5
  assign err = !mapped || size_bad;
  assign acc = psel && penable;
  assign wr_en = acc && pwrite && !err;

  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = acc && err;

  // ----------------------------------------------------------------
  // Common registers
  // ----------------------------------------------------------------
  logic [7:0] run_reg;
  logic [7:0] lock_reg;
  logic [5:0] gate_reg;
  logic byte0_we;

  assign byte0_we = wr_en && !in_ch && pstrb[0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_reg <= mtc_pkg::RUN_RST; // R7
    end else if (standby) begin
      run_reg <= mtc_pkg::RUN_RST; // R7
    end else if (byte0_we && paddr == mtc_pkg::OFS_RUN) begin
      run_reg <= pwdata[7:0] & mtc_pkg::CH_BIT_MASK; // R6 R11
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_reg <= mtc_pkg::LOCK_RST; // R15
    end else if (standby) begin
      lock_reg <= mtc_pkg::LOCK_RST; // R15
    end else if (byte0_we && paddr == mtc_pkg::OFS_LOCK) begin
      lock_reg <= pwdata[7:0] & mtc_pkg::CH_BIT_MASK; // R12 R11
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_reg <= mtc_pkg::GATE_RST; // R18
    end else if (standby) begin
      gate_reg <= mtc_pkg::GATE_RST; // R18
    end else if (byte0_we && paddr == mtc_pkg::OFS_GATE) begin
      gate_reg <= pwdata[5:0]; // R16
    end
  end

  // Per-channel views of the run and lockstep bits.
  logic [NCH-1:0] run_vec;
  logic [NCH-1:0] lock_vec;
  logic [NCH-1:0] run_d_reg;

  for (genvar c = 0; c < NCH; c++) begin : g_bits
    assign run_vec[c] = run_reg[mtc_pkg::CH_BIT[c]]; // R6
    assign lock_vec[c] = lock_reg[mtc_pkg::CH_BIT[c]]; // R12
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_d_reg <= '0;
    end else begin
      run_d_reg <= run_vec;
    end
  end

  // Gate vector: pins without a gate bit are always enabled.
  logic [NPIN-1:0] gate_vec;

  always_comb begin
    gate_vec = '1;
    for (int k = 0; k < 6; k++) begin
      gate_vec[mtc_pkg::GATE_PIN[k]] = gate_reg[k]; // R16 R20
    end
  end

  // ----------------------------------------------------------------
  // Capture inputs
  // ----------------------------------------------------------------
  logic [NPIN-1:0] tio_s;
  logic [NPIN-1:0] tio_d_reg;
  logic [NPIN-1:0] cap_edge;

  mtc_lockstep_bit_ch2 #(
    .W(NPIN)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .d(tio_in),
    .q(tio_s)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tio_d_reg <= '0;
    end else begin
      tio_d_reg <= tio_s;
    end
  end

  // Captures fire on the rising edge of the synchronised pin level.
  assign cap_edge = tio_s & ~tio_d_reg;

  // ----------------------------------------------------------------
  // Group preset and clear
  // ----------------------------------------------------------------
  logic preset_any;
  logic [NCH-1:0] clr_evt;
  logic sync_clr;

  // A counter write on any lockstep channel loads all of them.
  assign preset_any = wr_en && in_ch && (ofs == mtc_pkg::OFS_CNT) &&
                      lock_vec[chn]; // R13
  assign sync_clr = |(clr_evt & lock_vec); // R12

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  mtc_pkg::mtc_ctrl_t ctrl_reg [0:NCH-1];
  logic [3:0] ioc_reg [0:NCH-1];
  logic [GRW-1:0] cnt_w [0:NCH-1];
  logic [3:0][GRW-1:0] gr_w [0:NCH-1];
  logic [3:0] flags_w [0:NCH-1];
  logic [3:0] hit_w [0:NCH-1];
  logic [NPIN-1:0] lvl_reg;
  logic [NPIN-1:0] drive;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam int NGR = mtc_pkg::ch_ngr(c); // R2
    logic own;
    logic ioc_we;
    mtc_pkg::mtc_wr_t cw;

    assign own = wr_en && in_ch && (chn == 3'(c));
    assign ioc_we = own && ofs == mtc_pkg::OFS_IOC && pstrb[0];

    always_comb begin
      cw.data = pwdata[GRW-1:0];
      cw.gr_we = own && is_gr; // R1
      cw.gr_sel = gr_idx;
      cw.cnt_we = (own && ofs == mtc_pkg::OFS_CNT) ||
                  (preset_any && lock_vec[c]); // R13
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        ctrl_reg[c] <= '0;
      end else if (standby) begin
        ctrl_reg[c] <= '0;
      end else if (own && ofs == mtc_pkg::OFS_CTRL && pstrb[0]) begin
        ctrl_reg[c] <= pwdata[$bits(mtc_pkg::mtc_ctrl_t)-1:0];
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        ioc_reg[c] <= '0;
      end else if (standby) begin
        ioc_reg[c] <= '0;
      end else if (ioc_we) begin
        ioc_reg[c] <= pwdata[3:0];
      end
    end

    mtc_chan #(
      .NGR(NGR)
    ) u_chan (
      .clk(clk),
      .reset(reset),
      .standby(standby),
      .run(run_vec[c]), // R22
      .ctrl(ctrl_reg[c]),
      .wr(cw),
      .flag_wr(own && ofs == mtc_pkg::OFS_FLAG && pstrb[0]),
      .sync_clr(sync_clr && lock_vec[c]), // R14
      .cap_edge(cap_edge[c*4 +: 4]),
      .cnt(cnt_w[c]),
      .gr(gr_w[c]),
      .flags(flags_w[c]),
      .hit(hit_w[c]),
      .clr_evt(clr_evt[c])
    );

    // Pin outputs: one per compare-role register.
    for (genvar i = 0; i < 4; i++) begin : g_pin
      localparam int P = c * 4 + i;
      logic buffered;

      assign buffered = (i >= 2) && ctrl_reg[c].buf_en;
      assign drive[P] = (i < NGR) && !buffered &&
                        !ctrl_reg[c].cap[i] && gate_vec[P]; // R20
      assign tio_oe_n[P] = !drive[P];

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          lvl_reg[P] <= 1'b0;
        end else if (standby) begin
          lvl_reg[P] <= 1'b0;
        end else if (ioc_we && !run_vec[c]) begin
          lvl_reg[P] <= pwdata[i]; // R9
        end else if (ctrl_reg[c].pwm && run_d_reg[c] && !run_vec[c]) begin
          lvl_reg[P] <= ioc_reg[c][i]; // R10
        end else if (run_vec[c] && hit_w[c][i]) begin
          lvl_reg[P] <= !lvl_reg[P]; // R21
        end
      end
    end
  end

  // Outside PWM mode a stopped counter leaves the held level untouched.
  assign tio_out = lvl_reg; // R8

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data is sampled in the setup cycle and shown in the access
  // cycle, so a counter read returns its value one cycle earlier.
  logic [31:0] rdata;

  always_comb begin
    rdata = '0;
    if (!in_ch) begin
      if (paddr == mtc_pkg::OFS_RUN) begin
        rdata[7:0] = run_reg; // R11
      end else if (paddr == mtc_pkg::OFS_LOCK) begin
        rdata[7:0] = lock_reg; // R11
      end else if (paddr == mtc_pkg::OFS_GATE) begin
        rdata[7:0] = mtc_pkg::GATE_FIXED | {2'b00, gate_reg}; // R19
      end
    end else if (chn < 3'(NCH)) begin
      if (ofs == mtc_pkg::OFS_CTRL) begin
        rdata[$bits(mtc_pkg::mtc_ctrl_t)-1:0] = ctrl_reg[chn];
      end else if (ofs == mtc_pkg::OFS_IOC) begin
        rdata[3:0] = ioc_reg[chn];
      end else if (ofs == mtc_pkg::OFS_CNT) begin
        rdata[GRW-1:0] = cnt_w[chn];
      end else if (ofs == mtc_pkg::OFS_FLAG) begin
        rdata[3:0] = flags_w[chn];
      end else if (is_gr && gr_ok) begin
        rdata[GRW-1:0] = gr_w[chn][gr_idx];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= rdata;
    end
  end

endmodule : mtc_top

// ==== tb/mtc_top_asserts.sv ====
// Port checks for the timer common control.
`timescale 1ns/1ps
module mtc_top_asserts (
  input wire logic clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic standby, // Standby.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [3:0] pstrb, // Strobes.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic [19:0] tio_in, // Pin inputs.
  input wire logic [19:0] tio_out, // Pin levels.
  input wire logic [19:0] tio_oe_n // Pin drive, low active.
);
  // ------------------------------------------------------------
  // Shadow copies of run and gate bits
  // ------------------------------------------------------------
  logic [7:0] run_reg;
  logic [5:0] gate_reg;
  logic wr_ok;
  assign wr_ok = psel && penable && pwrite && pstrb[0];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) run_reg <= 8'h00;
    else if (standby) run_reg <= 8'h00;
    else if (wr_ok && paddr == mtc_pkg::OFS_RUN) run_reg <= pwdata[7:0];
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) gate_reg <= 6'h00;
    else if (standby) gate_reg <= 6'h00;
    else if (wr_ok && paddr == mtc_pkg::OFS_GATE) gate_reg <= pwdata[5:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence s_level_wr;
    wr_ok && paddr == 8'h24 && !run_reg[0];
  endsequence
  a_run_resvd: assert property (
    s_rd(mtc_pkg::OFS_RUN) |-> prdata[5:3] == 3'h0)
    else $error("run reserved bits not zero");
  a_lock_resvd: assert property (
    s_rd(mtc_pkg::OFS_LOCK) |-> prdata[5:3] == 3'h0)
    else $error("lockstep reserved bits not zero");
  a_gate_fixed: assert property (
    s_rd(mtc_pkg::OFS_GATE) |-> prdata[7:6] == 2'h3)
    else $error("gate fixed bits not one");
  a_narrow_err: assert property (
    psel && penable && pwrite && paddr[4] && paddr[7:5] inside
    {[3'h1:3'h5]} && pstrb[1:0] != 2'h3 |-> pslverr)
    else $error("narrow general write accepted");
  a_short_err: assert property (
    psel && penable && paddr[7:5] inside {3'h2, 3'h3} &&
    paddr[4:3] == 2'h3 |-> pslverr)
    else $error("absent register accepted");
  a_init_level: assert property (
    s_level_wr |=> tio_out[3:0] == $past(pwdata[3:0]))
    else $error("initial level not driven");
  a_gate_off: assert property (
    (~gate_reg & ~{tio_oe_n[19], tio_oe_n[18], tio_oe_n[15],
    tio_oe_n[17], tio_oe_n[16], tio_oe_n[13]}) == 6'h00)
    else $error("gated pin driven");
  a_standby_gate: assert property (
    standby |=> &{tio_oe_n[19:15], tio_oe_n[13]})
    else $error("gate not cleared by standby");
endmodule : mtc_top_asserts

bind mtc_top mtc_top_asserts u_chk (.clk(clk), .reset(reset),
  .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tio_in(tio_in),
  .tio_out(tio_out), .tio_oe_n(tio_oe_n));

// ==== tb/mtc_top_tb.sv ====
// Self-checking bench for the timer common control.
`timescale 1ns/1ps
module mtc_top_tb;
  logic clk, reset, standby, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [19:0] tio_in, tio_out, tio_oe_n;
  int n_mismatch, checked, cyc;
  mtc_top dut (.clk(clk), .reset(reset), .standby(standby), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tio_in(tio_in), .tio_out(tio_out), .tio_oe_n(tio_oe_n));
  always #5 clk = ~clk;
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] ca(input int c, input int o);
    return 8'(32 * (c + 1) + o);
  endfunction : ca
  task automatic chk(input string n, input logic [31:0] g,
      input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hF, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, 4'hF, r, e);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
      input string n);
    logic [31:0] r;
    rd(a, r);
    chk(n, r, x);
  endtask : rdc
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults();
    rdc(mtc_pkg::OFS_RUN, 32'h0, "run_init");
    rdc(mtc_pkg::OFS_LOCK, 32'h0, "lock_init");
    rdc(mtc_pkg::OFS_GATE, 32'hC0, "gate_init");
    for (int c = 0; c < 5; c++) begin
      for (int g = 0; g < ((c == 1 || c == 2) ? 2 : 4); g++) begin
        rdc(ca(c, 16 + 4 * g), 32'hFFFF, "gr_init");
      end
    end
    $display("t_defaults done");
  endtask : t_defaults
  task automatic t_access();
    logic [31:0] r;
    logic e;
    wr(mtc_pkg::OFS_RUN, 32'hC7);
    rdc(mtc_pkg::OFS_RUN, 32'hC7, "run_rsv");
    wr(mtc_pkg::OFS_RUN, 32'h00);
    wr(mtc_pkg::OFS_LOCK, 32'hC7);
    rdc(mtc_pkg::OFS_LOCK, 32'hC7, "lock_rsv");
    wr(mtc_pkg::OFS_LOCK, 32'h00);
    wr(mtc_pkg::OFS_GATE, 32'hC0);
    rdc(mtc_pkg::OFS_GATE, 32'hC0, "gate_fix");
    apb(1'b1, ca(0, 16), 32'h55, 4'h1, r, e);
    chk("narrow_err", e, 1'b1);
    rdc(ca(0, 16), 32'hFFFF, "narrow_kept");
    apb(1'b1, ca(0, 16), 32'h1234, 4'h3, r, e);
    rdc(ca(0, 16), 32'h1234, "gr_write");
    apb(1'b0, ca(1, 24), 32'h0, 4'hF, r, e);
    chk("short_err", e, 1'b1);
    $display("t_access done");
  endtask : t_access
  task automatic t_run();
    logic [31:0] r0, r1;
    for (int c = 0; c < 5; c += 4) begin
      wr(mtc_pkg::OFS_RUN, 32'h1 << (c == 4 ? 7 : c));
      rd(ca(c, 8), r0);
      rd(ca(c, 8), r1);
      chk("counting", r1 - r0, 32'h3);
      wr(mtc_pkg::OFS_RUN, 32'h0);
      rd(ca(c, 8), r0);
      rd(ca(c, 8), r1);
      chk("halted", r1, r0);
    end
    $display("t_run done");
  endtask : t_run
  task automatic t_stop(input logic pwm);
    logic [31:0] r;
    wr(ca(0, 0), {23'h0, pwm, 8'h0});
    wr(ca(0, 4), 32'h0);
    wr(ca(0, 8), 32'h0);
    wr(ca(0, 12), 32'h0);
    wr(ca(0, 16), 32'h8);
    wr(mtc_pkg::OFS_RUN, 32'h1);
    repeat (20) @(posedge clk);
    chk("level_run", tio_out[0], 1'b1);
    wr(mtc_pkg::OFS_RUN, 32'h0);
    repeat (3) @(posedge clk);
    chk("level_stop", tio_out[0], !pwm);
    rd(ca(0, 12), r);
    chk("flag_a", r[0], 1'b1);
    wr(ca(0, 0), 32'h0);
    $display("t_stop done");
  endtask : t_stop
  task automatic t_lock();
    logic [31:0] r0, r1, r2;
    wr(mtc_pkg::OFS_LOCK, 32'hC1);
    rd(ca(1, 8), r2);
    wr(ca(0, 8), 32'h10);
    rdc(ca(3, 8), 32'h10, "preset3");
    rdc(ca(4, 8), 32'h10, "preset4");
    rdc(ca(1, 8), r2, "independent");
    wr(ca(0, 16), 32'h20);
    wr(ca(0, 0), 32'h1);
    wr(ca(3, 0), 32'h3);
    wr(mtc_pkg::OFS_RUN, 32'hC1);
    repeat (40) @(posedge clk);
    wr(mtc_pkg::OFS_RUN, 32'h0);
    rd(ca(0, 8), r0);
    rd(ca(3, 8), r1);
    rd(ca(4, 8), r2);
    chk("sync_clear", r1 == r0 || r1 + 1 == r0, 1'b1);
    chk("no_clear", r2 == r0, 1'b0);
    wr(mtc_pkg::OFS_LOCK, 32'h0);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_gate();
    int pins [6] = '{13, 16, 17, 15, 18, 19};
    logic [5:0] m;
    for (int i = 0; i < 6; i++) begin
      wr(mtc_pkg::OFS_GATE, 32'hC0 | (32'h1 << i));
      @(posedge clk);
      m = 6'h0;
      for (int j = 0; j < 6; j++) m[j] = !tio_oe_n[pins[j]];
      chk("gate_pins", m, 32'h1 << i);
    end
    wr(mtc_pkg::OFS_GATE, 32'hC0);
    $display("t_gate done");
  endtask : t_gate
  task automatic t_standby();
    wr(mtc_pkg::OFS_GATE, 32'hFF);
    wr(mtc_pkg::OFS_LOCK, 32'h41);
    wr(mtc_pkg::OFS_RUN, 32'h02);
    wr(ca(4, 28), 32'h1234);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    t_defaults();
  endtask : t_standby
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // A hung handshake must still reach the verdict.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    standby = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    tio_in = 20'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_access();
    t_run();
    t_stop(1'b0);
    t_stop(1'b1);
    t_lock();
    t_gate();
    t_standby();
    end_of_test();
  end
endmodule : mtc_top_tb
